// *** ftl_defines.svh ***
// Purpose: Shared constants of the flash/torch light sequencer and its host
// Assumes: 20 MHz clock on both ends
// Notes:   Times are given in their own unit, cycle counts are derived
`ifndef FTL_DEFINES_SVH
`define FTL_DEFINES_SVH
// ****************************************************************
// Clock and times
// ****************************************************************
`define FTL_CLK_MHZ           20
`define FTL_POWER_WAIT_US     5000
`define FTL_TRIG_WAIT_US      5000
`define FTL_BURST_RISE_US     1000
`define FTL_STEADY_RISE_US    300
`define FTL_BURST_STEADY_US   500
`define FTL_BURST_UNIT_US     100
`define FTL_US2CYC(us)        ((us) * `FTL_CLK_MHZ)
// ****************************************************************
// Device register addresses
// ****************************************************************
`define FTL_ADDR_ENABLE       8'h01
`define FTL_ADDR_CTRL         8'h02
`define FTL_ADDR_OTHERS       8'h04
`define FTL_ADDR_LIGHT        8'h05
`define FTL_ADDR_STATUS       8'h06
// ****************************************************************
// Device field positions and reset values
// ****************************************************************
`define FTL_EN_CH1_BIT        0
`define FTL_EN_CH2_BIT        1
`define FTL_CTRL_EDGE_BIT     4
`define FTL_CTRL_TIME_LSB     0
`define FTL_OTH_DET_LSB       2
`define FTL_LIGHT_TORCH_BIT   0
`define FTL_LIGHT_FLASH_BIT   1
`define FTL_STAT_OVERHEAT_BIT 4
`define FTL_RST_ENABLE        2'h0
`define FTL_RST_TIME          4'h0
`define FTL_RST_DET           3'h0
// ****************************************************************
// Thermal threshold table, millivolts
// ****************************************************************
`define FTL_DET_BASE_MV       11'h258
`define FTL_DET_STEP_MV       11'h046
`define FTL_DET_MAX_CODE      3'h6
// ****************************************************************
// Host APB map
// ****************************************************************
`define FTL_APB_PINS          12'h000
`define FTL_APB_CMD           12'h004
`define FTL_APB_STATUS        12'h008
`define FTL_CMD_READ_BIT      16
`define FTL_PIN_BURST_BIT     0
`define FTL_PIN_STEADY_BIT    1
`endif

// *** ftl_pkg.sv ***
// Purpose: Types of the flash/torch light sequencer
// Assumes: ftl_defines.svh holds the numbers
// Notes:   Types only
package ftl_pkg;
    typedef enum logic [1:0] {BURST_IDLE, BURST_RUN, BURST_SPENT} ftl_burst_e;
    typedef enum logic [1:0] {LIGHT_OFF, LIGHT_STEADY, LIGHT_BURST} ftl_light_e;
    typedef enum logic [1:0] {CMD_IDLE, CMD_PEND, CMD_READ} ftl_cmd_e;
endpackage : ftl_pkg

// *** ftl_link_if.sv ***
// Purpose: Link between host controller and light sequencer
// Assumes: Both ends on one clock
// Notes:   Register port stands in for the serial bus
`timescale 1ns/1ns
interface ftl_link_if;
    logic       burst_pin;
    logic       steady_pin;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    modport device (input burst_pin, steady_pin, reg_wr, reg_rd, reg_addr, reg_wdata,
                    output reg_rdata, reg_rvalid);
    modport host   (output burst_pin, steady_pin, reg_wr, reg_rd, reg_addr, reg_wdata,
                    input reg_rdata, reg_rvalid);
endinterface : ftl_link_if

// *** ftl_device.sv ***
// Purpose: Flash/torch light sequencer, device end
// Assumes: Link signals come from logic on clk; sense_mv is asynchronous
// Notes:   Outputs are requests to the analog current sources
// What this block does
// - Overheat powers down, sets overheat status flag
// - Control bit selects level or edge bursts
// - Level mode: burst while request held, timer-limited
// - Steady light while steady request is held
// - Edge mode: rising request starts timer-limited burst
// - Burst timer starts on request rising edge
// - Level mode: release or expiry cuts burst
// - Level mode: request falling edge clears timer
// - Edge mode: expiry cuts burst despite request
// - Edge mode: timer clears itself at expiry
// - Host waits 5ms, then writes enable pair
// - Self reset; any enable bit powers up
// - Host waits 5ms after enable before burst
// - Requests accepted whatever the boost level
// - Current settles within 1ms, 300us, 500us
// - Host waits 5ms after enable before steady
// - Steady request falling edge cuts current
// - Clearing both enables leaves shutdown, resets registers
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "ftl_defines.svh"
module ftl_device
    import ftl_pkg::*;
#(
    parameter int BURST_UNIT_CYCLES  = `FTL_US2CYC(`FTL_BURST_UNIT_US),
    parameter int BURST_RISE_CYCLES  = `FTL_US2CYC(`FTL_BURST_RISE_US),
    parameter int STEADY_RISE_CYCLES = `FTL_US2CYC(`FTL_STEADY_RISE_US),
    parameter int BURST_STEADY_CYCLES = `FTL_US2CYC(`FTL_BURST_STEADY_US)
) (
    input  wire logic        clk,
    input  wire logic        reset,
    ftl_link_if.device       link,
    input  wire logic [10:0] sense_mv,
    output logic             powered,
    output logic             drive_burst,
    output logic             drive_steady,
    output logic             level_reached,
    output logic             overheat
);
// ****************************************************************
// Registers
// ****************************************************************
    logic [1:0]  enable_q;
    logic        edge_mode_q;
    logic [3:0]  burst_time_q;
    logic [2:0]  threshold_q;
    logic        flash_bit_q;
    logic        torch_bit_q;
    logic        shutdown_q;
    logic        overheat_q;
    logic [7:0]  rdata_q;
    logic        rvalid_q;
    logic [10:0] sense_meta_q;
    logic [10:0] sense_q;
    logic        burst_prev_q;
    ftl_burst_e  burst_q;
    logic [31:0] timer_q;
    ftl_light_e  light_q;
    logic [31:0] settle_q;
    logic        powered_q;
    logic        drive_burst_q;
    logic        drive_steady_q;
    logic        level_q;

    logic        wr_en;
    logic        recover;
    logic        is_on;
    logic        burst_req;
    logic        steady_req;
    logic        burst_rise;
    logic        expire;
    logic [31:0] limit;
    logic [10:0] threshold_mv;
    logic [2:0]  det_code;
    logic        too_hot;
    ftl_light_e  light_d;

    assign wr_en   = link.reg_wr && link.reg_addr == `FTL_ADDR_ENABLE;
    assign recover = wr_en && link.reg_wdata[1:0] == 2'h0;
    assign is_on   = (enable_q != 2'h0) && !shutdown_q;
// ****************************************************************
// Register writes
// ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            enable_q <= `FTL_RST_ENABLE;
        end else if (wr_en) begin
            enable_q <= link.reg_wdata[1:0];
        end
    end

    // Config writes are dropped while shut down; recovery wipes them
    always_ff @(posedge clk) begin
        if (reset || recover) begin
            edge_mode_q  <= 1'b0;
            burst_time_q <= `FTL_RST_TIME;
            threshold_q  <= `FTL_RST_DET;
            flash_bit_q  <= 1'b0;
            torch_bit_q  <= 1'b0;
        end else if (link.reg_wr && !shutdown_q) begin
            case (link.reg_addr)
                `FTL_ADDR_CTRL: begin
                    edge_mode_q  <= link.reg_wdata[`FTL_CTRL_EDGE_BIT];
                    burst_time_q <= link.reg_wdata[`FTL_CTRL_TIME_LSB +: 4];
                end
                `FTL_ADDR_OTHERS: begin
                    threshold_q <= link.reg_wdata[`FTL_OTH_DET_LSB +: 3];
                end
                `FTL_ADDR_LIGHT: begin
                    flash_bit_q <= link.reg_wdata[`FTL_LIGHT_FLASH_BIT];
                    torch_bit_q <= link.reg_wdata[`FTL_LIGHT_TORCH_BIT];
                end
                default: begin
                end
            endcase
        end
    end
// ****************************************************************
// Register reads
// ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= link.reg_rd;
            case (link.reg_addr)
                `FTL_ADDR_ENABLE: rdata_q <= {6'h00, enable_q};
                `FTL_ADDR_CTRL:   rdata_q <= {3'h0, edge_mode_q, burst_time_q};
                `FTL_ADDR_OTHERS: rdata_q <= {3'h0, threshold_q, 2'h0};
                `FTL_ADDR_LIGHT:  rdata_q <= {6'h00, flash_bit_q, torch_bit_q};
                `FTL_ADDR_STATUS: rdata_q <= {3'h0, overheat_q, 4'h0};
                default:          rdata_q <= 8'h00;
            endcase
        end
    end
// ****************************************************************
// Thermal watch
// ****************************************************************
    // Slow analog code; a stale bit for one cycle only delays the trip
    always_ff @(posedge clk) begin
        if (reset) begin
            sense_meta_q <= 11'h7FF;
            sense_q      <= 11'h7FF;
        end else begin
            sense_meta_q <= sense_mv;
            sense_q      <= sense_meta_q;
        end
    end

    assign det_code     = (threshold_q > `FTL_DET_MAX_CODE) ? `FTL_DET_MAX_CODE : threshold_q;
    assign threshold_mv = `FTL_DET_BASE_MV + 11'(`FTL_DET_STEP_MV * det_code);
    assign too_hot      = is_on && (sense_q < threshold_mv);

    always_ff @(posedge clk) begin
        if (reset) begin
            shutdown_q <= 1'b0;
            overheat_q <= 1'b0;
        end else if (too_hot) begin
            shutdown_q <= 1'b1;
            overheat_q <= 1'b1;
        end else if (recover) begin
            shutdown_q <= 1'b0;
            overheat_q <= 1'b0;
        end
    end
// ****************************************************************
// Burst sequencer
// ****************************************************************
    // No wait on the boost node: requests act at once
    assign burst_req  = link.burst_pin || flash_bit_q;
    assign steady_req = link.steady_pin || torch_bit_q;
    assign burst_rise = burst_req && !burst_prev_q;
    assign limit      = (32'(burst_time_q) + 32'h1) * 32'(BURST_UNIT_CYCLES);
    assign expire     = timer_q >= limit - 32'h1;

    always_ff @(posedge clk) begin
        if (reset) begin
            burst_prev_q <= 1'b0;
        end else begin
            burst_prev_q <= burst_req;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !is_on) begin
            burst_q <= BURST_IDLE;
        end else begin
            case (burst_q)
                BURST_IDLE: begin
                    if (burst_rise) begin
                        burst_q <= BURST_RUN;
                    end
                end
                BURST_RUN: begin
                    if (edge_mode_q) begin
                        if (expire) begin
                            burst_q <= BURST_IDLE;
                        end
                    end else if (!burst_req) begin
                        burst_q <= BURST_IDLE;
                    end else if (expire) begin
                        burst_q <= BURST_SPENT;
                    end
                end
                BURST_SPENT: begin
                    if (!burst_req || edge_mode_q) begin
                        burst_q <= BURST_IDLE;
                    end
                end
                default: begin
                    burst_q <= BURST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset || burst_q != BURST_RUN) begin
            timer_q <= 32'h0;
        end else if (expire) begin
            timer_q <= 32'h0;
        end else begin
            timer_q <= timer_q + 32'h1;
        end
    end
// ****************************************************************
// Light selection and settling
// ****************************************************************
    always_comb begin
        light_d = LIGHT_OFF;
        if (is_on && burst_q == BURST_RUN) begin
            light_d = LIGHT_BURST;
        end else if (is_on && steady_req) begin
            light_d = LIGHT_STEADY;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            light_q  <= LIGHT_OFF;
            settle_q <= 32'h0;
        end else begin
            light_q <= light_d;
            if (light_d != light_q) begin
                case (light_d)
                    LIGHT_BURST: begin
                        settle_q <= (light_q == LIGHT_STEADY) ?
                                    32'(BURST_STEADY_CYCLES) : 32'(BURST_RISE_CYCLES);
                    end
                    LIGHT_STEADY: settle_q <= 32'(STEADY_RISE_CYCLES);
                    default:      settle_q <= 32'h0;
                endcase
            end else if (settle_q != 32'h0) begin
                settle_q <= settle_q - 32'h1;
            end
        end
    end
// ****************************************************************
// Outputs
// ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            powered_q      <= 1'b0;
            drive_burst_q  <= 1'b0;
            drive_steady_q <= 1'b0;
            level_q        <= 1'b0;
        end else begin
            powered_q      <= is_on;
            drive_burst_q  <= light_d == LIGHT_BURST;
            drive_steady_q <= light_d == LIGHT_STEADY;
            level_q        <= light_q != LIGHT_OFF && light_d == light_q
                              && settle_q <= 32'h1;
        end
    end

    assign powered         = powered_q;
    assign drive_burst     = drive_burst_q;
    assign drive_steady    = drive_steady_q;
    assign level_reached   = level_q;
    assign overheat        = overheat_q;
    assign link.reg_rdata  = rdata_q;
    assign link.reg_rvalid = rvalid_q;

endmodule : ftl_device

// *** ftl_host.sv ***
// Purpose: Host controller driving the light sequencer
// Assumes: Software reaches it over APB; same clock as the device
// Notes:   Holds back enable and trigger writes until waits elapse
`timescale 1ns/1ns
`include "ftl_defines.svh"
module ftl_host
    import ftl_pkg::*;
#(
    parameter int POWER_WAIT_CYCLES = `FTL_US2CYC(`FTL_POWER_WAIT_US),
    parameter int TRIG_WAIT_CYCLES  = `FTL_US2CYC(`FTL_TRIG_WAIT_US)
) (
    input  wire logic        clk,
    input  wire logic        reset,
    ftl_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
// ****************************************************************
// State
// ****************************************************************
    logic [31:0] power_cnt_q;
    logic [31:0] trig_cnt_q;
    logic        trig_armed_q;
    logic [1:0]  pins_q;
    ftl_cmd_e    cmd_q;
    logic [7:0]  cmd_addr_q;
    logic [7:0]  cmd_data_q;
    logic        cmd_read_q;
    logic [7:0]  last_rdata_q;
    logic        wr_q;
    logic        rd_q;
    logic        burst_q;
    logic        steady_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    logic        access;
    logic        power_ok;
    logic        trig_ok;
    logic        cmd_ok;
    logic        launch;

    assign access   = psel && penable && !pready_q;
    assign power_ok = power_cnt_q == 32'(POWER_WAIT_CYCLES);
    assign trig_ok  = trig_armed_q && trig_cnt_q == 32'(TRIG_WAIT_CYCLES);
    // Enable write waits for supply settling, light writes with a bit set wait for power-up
    assign cmd_ok   = cmd_read_q ? 1'b1 :
                      (cmd_addr_q == `FTL_ADDR_ENABLE) ? power_ok :
                      (cmd_addr_q == `FTL_ADDR_LIGHT && cmd_data_q[1:0] != 2'h0) ?
                      trig_ok : 1'b1;
    assign launch   = cmd_q == CMD_PEND && cmd_ok;
// ****************************************************************
// Wait timers
// ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            power_cnt_q <= 32'h0;
        end else if (!power_ok) begin
            power_cnt_q <= power_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trig_armed_q <= 1'b0;
            trig_cnt_q   <= 32'h0;
        end else if (launch && !cmd_read_q && cmd_addr_q == `FTL_ADDR_ENABLE) begin
            trig_armed_q <= cmd_data_q[1:0] != 2'h0;
            trig_cnt_q   <= 32'h0;
        end else if (trig_armed_q && !trig_ok) begin
            trig_cnt_q <= trig_cnt_q + 32'h1;
        end
    end
// ****************************************************************
// APB slave
// ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
            pins_q    <= 2'h0;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            // A command write stalls while the previous one is pending
            if (access && !(pwrite && paddr == `FTL_APB_CMD && cmd_q != CMD_IDLE)) begin
                pready_q <= 1'b1;
                prdata_q <= 32'h0;
                case (paddr)
                    `FTL_APB_PINS: begin
                        if (pwrite) begin
                            pins_q <= pwdata[1:0];
                        end
                        prdata_q <= {30'h0, pins_q};
                    end
                    `FTL_APB_CMD: begin
                    end
                    `FTL_APB_STATUS: begin
                        prdata_q <= {16'h0, last_rdata_q, 5'h0, trig_ok, power_ok,
                                     cmd_q != CMD_IDLE};
                    end
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end
// ****************************************************************
// Command engine
// ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_q        <= CMD_IDLE;
            cmd_addr_q   <= 8'h00;
            cmd_data_q   <= 8'h00;
            cmd_read_q   <= 1'b0;
            last_rdata_q <= 8'h00;
            wr_q         <= 1'b0;
            rd_q         <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            case (cmd_q)
                CMD_IDLE: begin
                    if (access && pwrite && paddr == `FTL_APB_CMD) begin
                        cmd_addr_q <= pwdata[15:8];
                        cmd_data_q <= pwdata[7:0];
                        cmd_read_q <= pwdata[`FTL_CMD_READ_BIT];
                        cmd_q      <= CMD_PEND;
                    end
                end
                CMD_PEND: begin
                    if (launch) begin
                        wr_q  <= !cmd_read_q;
                        rd_q  <= cmd_read_q;
                        cmd_q <= cmd_read_q ? CMD_READ : CMD_IDLE;
                    end
                end
                CMD_READ: begin
                    if (link.reg_rvalid) begin
                        last_rdata_q <= link.reg_rdata;
                        cmd_q        <= CMD_IDLE;
                    end
                end
                default: cmd_q <= CMD_IDLE;
            endcase
        end
    end
// ****************************************************************
// Trigger pins
// ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            burst_q  <= 1'b0;
            steady_q <= 1'b0;
        end else begin
            burst_q  <= pins_q[`FTL_PIN_BURST_BIT] && trig_ok;
            steady_q <= pins_q[`FTL_PIN_STEADY_BIT] && trig_ok;
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign link.burst_pin  = burst_q;
    assign link.steady_pin = steady_q;
    assign link.reg_wr     = wr_q;
    assign link.reg_rd     = rd_q;
    assign link.reg_addr   = cmd_addr_q;
    assign link.reg_wdata  = cmd_data_q;

endmodule : ftl_host

// *** ftl_link_asserts.sv ***
// Purpose: Checker for the link and the sequencer outputs
// Assumes: One clock, reset synchronous high
// Notes:   Burst limit is sixteen time units, the longest code
`timescale 1ns/1ns
module ftl_link_asserts #(
    parameter int BURST_UNIT_CYCLES = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    input wire logic powered,
    input wire logic drive_burst,
    input wire logic drive_steady,
    input wire logic level_reached,
    input wire logic overheat
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    int unsigned on_q;
    // Counter, since a repetition this long would unroll badly
    always_ff @(posedge clk) begin
        on_q <= (reset || !drive_burst) ? 0 : on_q + 1;
    end
    rvalid_timing_a: assert property (reg_rd |=> reg_rvalid) else $error("read answer late");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray answer");
    shutdown_off_a: assert property (overheat |=> !powered && !drive_burst && !drive_steady)
        else $error("light on in shutdown");
    burst_excl_a: assert property (!(drive_burst && drive_steady))
        else $error("both currents on");
    steady_power_a: assert property (drive_steady |-> $past(powered))
        else $error("steady while off");
    burst_power_a: assert property ($rose(drive_burst) |-> $past(powered))
        else $error("burst while off");
    burst_limit_a: assert property (on_q <= 16 * BURST_UNIT_CYCLES)
        else $error("burst too long");
    settle_cause_a: assert property ($rose(level_reached) |-> $past(drive_burst) || $past(drive_steady))
        else $error("settled with light off");
endmodule : ftl_link_asserts

// *** test_flash_torch_light_sequencer.sv ***
// Purpose: Bench for host and sequencer
// Assumes: Waits cut to 50 cycles, burst unit 4 cycles
// Notes:   Time code 3 gives a 16 cycle burst
`timescale 1ns/1ns
module test_flash_torch_light_sequencer;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [10:0] sense = 11'h7D0;
    logic [31:0] prdata, rd_q;
    logic        pready, pslverr, err_q, pwr, brst, stdy, lvl, ovh;
    int          fail_count = 0;
    int          n_tests = 0;
    always #25 clk = ~clk;
    ftl_link_if ftl_link_if_i ();
    ftl_device #(.BURST_UNIT_CYCLES(4), .BURST_RISE_CYCLES(20), .STEADY_RISE_CYCLES(6))
        ftl_device_i (.clk(clk), .reset(reset), .link(ftl_link_if_i),
        .sense_mv(sense), .powered(pwr), .drive_burst(brst), .drive_steady(stdy),
        .level_reached(lvl), .overheat(ovh));
    ftl_host #(.POWER_WAIT_CYCLES(50), .TRIG_WAIT_CYCLES(50)) ftl_host_i (.clk(clk),
        .reset(reset), .link(ftl_link_if_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ftl_link_asserts ftl_link_asserts_i (.clk(clk), .reset(reset),
        .reg_rd(ftl_link_if_i.reg_rd), .reg_rvalid(ftl_link_if_i.reg_rvalid), .powered(pwr),
        .drive_burst(brst), .drive_steady(stdy), .level_reached(lvl), .overheat(ovh));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input string s, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %b seen %b", s, e, g);
            fail_count++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_q <= prdata;
        err_q <= pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic cmd(input logic [16:0] c);
        apb(1'b1, 12'h004, {15'h0, c});
        cyc(6);
    endtask : cmd
    task automatic poll(input int b);
        do apb(1'b0, 12'h008, 32'h0); while (rd_q[b] !== 1'b1);
    endtask : poll
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial begin
        cyc(20000);
        fail_count++;
        complete_run();
    end
    initial begin
        cyc(10);
        reset <= 1'b0;
        poll(1);
        cmd(17'h00101);
        cmd(17'h00203);
        poll(2);
        apb(1'b1, 12'h000, 32'h1);
        cyc(2);
        chk("pin", 1'b1, ftl_link_if_i.burst_pin);
        chk("level burst", 1'b1, brst);
        apb(1'b1, 12'h000, 32'h0);
        cyc(2);
        chk("release", 1'b0, brst);
        apb(1'b1, 12'h000, 32'h1);
        cyc(24);
        chk("expiry", 1'b0, brst);
        apb(1'b1, 12'h000, 32'h2);
        cyc(10);
        chk("steady", 1'b1, stdy);
        chk("settled", 1'b1, lvl);
        apb(1'b1, 12'h000, 32'h3);
        cyc(2);
        chk("priority", 1'b1, brst);
        cyc(24);
        chk("back to steady", 1'b1, stdy);
        apb(1'b1, 12'h000, 32'h0);
        cyc(2);
        chk("steady off", 1'b0, stdy);
        $display("level and steady done");
        cmd(17'h00213);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        chk("edge burst", 1'b1, brst);
        cyc(20);
        apb(1'b1, 12'h000, 32'h1);
        cyc(24);
        chk("edge expiry", 1'b0, brst);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slave error", 1'b1, err_q);
        cmd(17'h00501);
        chk("torch bit", 1'b1, stdy);
        cmd(17'h00500);
        chk("torch bit off", 1'b0, stdy);
        $display("edge done");
        // Threshold code 3 trips at 810 mV; 700 mV would not trip code 0
        cmd(17'h0040C);
        sense <= 11'h2BC;
        cyc(10);
        chk("overheat", 1'b1, ovh);
        cmd(17'h10600);
        apb(1'b0, 12'h008, 32'h0);
        chk("status flag", 1'b1, rd_q[12]);
        sense <= 11'h7D0;
        cmd(17'h00100);
        cmd(17'h00101);
        chk("recovered", 1'b0, ovh);
        chk("powered", 1'b1, pwr);
        $display("thermal done");
        complete_run();
    end
endmodule : test_flash_torch_light_sequencer
